// ===== design/l1_cache_maint_ctrl.sv
`include "lcm_defines.svh"

// How it works
// - Set/way walk; select reads data or instruction geometry.
// - Size word packs line, ways, sets.
// - Any write invalidates whole instruction cache.
// - Control bits 16/17 enable data/instruction caches.
// - Maintenance faults reported asynchronously.
// - No hard fault escalation when handler enabled.
// - Barrier completes only after ops finish.
// - Maintenance ops complete in issue order.
// - Tight memory controls at consecutive words, zero reset.
// - Port controls reset zero and 0x800.
// - Aux bus fault status resets to zero.
// - Unprivileged access raises bus fault.
// - Set/way takes way [31:30], set [13:5].
// - Tight memory disabled routes to AXI.
// - Maintenance registers read zero; only invalidate-all ignores data.
module l1_cache_maint_ctrl (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ppbSel,
  input  wire logic        ppbWrite,
  input  wire logic        ppbPriv,
  input  wire logic [31:0] ppbAddr,
  input  wire logic [31:0] ppbWdata,
  output logic      [31:0] ppbRdata,
  output logic             ppbFault,
  input  wire logic        eccConfigured,
  input  wire logic        busFaultHandlerEn,
  input  wire logic        maintErr,
  input  wire logic        barrierReq,
  output logic             cmdValid,
  output logic      [2:0]  cmdKind,
  output logic      [31:0] cmdAddr,
  output logic             dcacheEnable,
  output logic             icacheEnable,
  output logic             itcmEnable,
  output logic             dtcmEnable,
  output logic             periphPortEnable,
  output logic             barrierDone,
  output logic             loadStoreHold,
  output logic             bus_fault_exception,
  output logic             hard_fault_exception
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstMeta_reg;
  logic rstSync_reg;
  logic rstN;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  assign rstN = rstSync_reg;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic                     dcEn_reg;
  logic                     icEn_reg;
  logic                     csselInst_reg;
  logic [31:0]              itcm_reg;
  logic [31:0]              dtcm_reg;
  logic [31:0]              ahbp_reg;
  logic [31:0]              aux_cache_control_reg;
  logic [31:0]              slave_port_control_reg;
  logic [31:0]              aux_bus_fault_status_reg;
  logic                     strapDone_reg;
  logic [31:0]              rdata_reg;
  logic                     privFault_reg;
  logic                     cmdValid_reg;
  logic [2:0]               cmdKind_reg;
  logic [31:0]              cmdAddr_reg;
  logic                     barDone_reg;
  logic                     hold_reg;
  logic                     bus_fault_exception_reg;
  logic                     hard_fault_exception_reg;
  lcm_pkg::lcm_barrier_type bar_reg;
  lcm_pkg::lcm_barrier_type bar_next;
  lcm_pkg::lcm_op_type      opKind;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire        wrEn         = ppbSel & ppbWrite & ppbPriv;
  wire        rdEn         = ppbSel & ~ppbWrite & ppbPriv;
  wire        unprivAcc    = ppbSel & ~ppbPriv;
  wire        hitCcr       = ppbAddr == `LCM_ADDR_CONFIG_CONTROL;
  wire        hitCcsidr    = ppbAddr == `LCM_ADDR_CACHE_SIZE_ID;
  wire        hitCssel     = ppbAddr == `LCM_ADDR_CACHE_SIZE_SELECT;
  wire        hitIcInvAll  = ppbAddr == `LCM_ADDR_IC_INV_ALL;
  wire        hitIcInvAddr = ppbAddr == `LCM_ADDR_IC_INV_ADDR;
  wire        hitDcInvSw   = ppbAddr == `LCM_ADDR_DC_INV_SETWAY;
  wire        hitDcClnU    = ppbAddr == `LCM_ADDR_DC_CLEAN_UNIFY;
  wire        hitDcClnC    = ppbAddr == `LCM_ADDR_DC_CLEAN_COHERENT;
  wire        hitItcm      = ppbAddr == `LCM_ADDR_INST_TCM_CONTROL;
  wire        hitDtcm      = ppbAddr == `LCM_ADDR_DATA_TCM_CONTROL;
  wire        hitAhbp      = ppbAddr == `LCM_ADDR_PERIPH_PORT_CONTROL;
  wire        hitCacr      = ppbAddr == `LCM_ADDR_AUX_CACHE_CONTROL;
  wire        hitAhbscr    = ppbAddr == `LCM_ADDR_SLAVE_PORT_CONTROL;
  wire        hitAbfsr     = ppbAddr == `LCM_ADDR_AUX_BUS_FAULT_STAT;
  wire        maintHit     = hitIcInvAll | hitIcInvAddr | hitDcInvSw | hitDcClnU | hitDcClnC;
  wire        opIssue      = wrEn & maintHit;

  // ----------------------------------------
  // Maintenance command build
  // ----------------------------------------
  assign opKind = hitIcInvAll  ? lcm_pkg::LCM_OP_IC_INV_ALL :
                  hitIcInvAddr ? lcm_pkg::LCM_OP_IC_INV_ADDR :
                  hitDcInvSw   ? lcm_pkg::LCM_OP_DC_INV_SETWAY :
                  hitDcClnU    ? lcm_pkg::LCM_OP_DC_CLEAN_UNIFY :
                  hitDcClnC    ? lcm_pkg::LCM_OP_DC_CLEAN_COHER :
                                 lcm_pkg::LCM_OP_NONE;

  // Way and set only, reserved bits dropped
  wire [31:0] setWayAddr   = ppbWdata & `LCM_SETWAY_MASK;
  // Invalidate-all ignores its data
  wire [31:0] opAddr       = hitIcInvAll ? `LCM_RST_ZERO :
                             hitDcInvSw  ? setWayAddr : ppbWdata;

  // ----------------------------------------
  // Size identification word
  // ----------------------------------------
  wire [31:0] ccsidrData   = csselInst_reg ?
                             {`LCM_CACHE_SIZE_ID_PAD, `LCM_IC_SETS_M1, `LCM_IC_ASSOC_M1, `LCM_IC_LINE_CODE} :
                             {`LCM_CACHE_SIZE_ID_PAD, `LCM_DC_SETS_M1, `LCM_DC_ASSOC_M1, `LCM_DC_LINE_CODE};

  wire [31:0] ccrData      = (32'(dcEn_reg) << `LCM_DATA_CACHE_ENABLE_BIT_BIT) | (32'(icEn_reg) << `LCM_INST_CACHE_ENABLE_BIT_BIT);
  wire [31:0] csselData    = 32'(csselInst_reg) << `LCM_CSSEL_IND_BIT;

  // ----------------------------------------
  // Read data select
  // ----------------------------------------
  // Write-only maintenance addresses fall to zero
  wire [31:0] rdataNext    = !rdEn     ? `LCM_RST_ZERO :
                             hitCcr    ? ccrData :
                             hitCcsidr ? ccsidrData :
                             hitCssel  ? csselData :
                             hitItcm   ? itcm_reg :
                             hitDtcm   ? dtcm_reg :
                             hitAhbp   ? ahbp_reg :
                             hitCacr   ? aux_cache_control_reg :
                             hitAhbscr ? slave_port_control_reg :
                             hitAbfsr  ? aux_bus_fault_status_reg :
                                         `LCM_RST_ZERO;

  // ----------------------------------------
  // In-order completion tracking
  // ----------------------------------------
  logic pipeDone;
  logic pipeEmpty;

  lcm_op_pipe uPipe (
    .clk   (clk),
    .rstN  (rstN),
    .issue (opIssue),
    .done  (pipeDone),
    .empty (pipeEmpty)
  );

  wire maintFault = pipeDone & maintErr;

  // ----------------------------------------
  // Barrier sequencing
  // ----------------------------------------
  always_comb begin
    bar_next = bar_reg;
    case (bar_reg)
      lcm_pkg::LCM_BAR_IDLE: begin
        if (barrierReq) begin
          bar_next = lcm_pkg::LCM_BAR_WAIT;
        end
      end
      lcm_pkg::LCM_BAR_WAIT: begin
        if (pipeEmpty && !opIssue) begin
          bar_next = lcm_pkg::LCM_BAR_DONE;
        end
      end
      lcm_pkg::LCM_BAR_DONE: begin
        bar_next = lcm_pkg::LCM_BAR_IDLE;
      end
      default: begin
        bar_next = lcm_pkg::LCM_BAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      bar_reg     <= lcm_pkg::LCM_BAR_IDLE;
      barDone_reg <= 1'b0;
      hold_reg    <= 1'b0;
    end else begin
      bar_reg     <= bar_next;
      barDone_reg <= bar_next == lcm_pkg::LCM_BAR_DONE;
      hold_reg    <= bar_next == lcm_pkg::LCM_BAR_WAIT;
    end
  end

  // ----------------------------------------
  // Cache enables and size select
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dcEn_reg      <= 1'b0;
      icEn_reg      <= 1'b0;
      csselInst_reg <= 1'b0;
    end else begin
      if (wrEn && hitCcr) begin
        dcEn_reg <= ppbWdata[`LCM_DATA_CACHE_ENABLE_BIT_BIT];
        icEn_reg <= ppbWdata[`LCM_INST_CACHE_ENABLE_BIT_BIT];
      end
      if (wrEn && hitCssel) begin
        csselInst_reg <= ppbWdata[`LCM_CSSEL_IND_BIT];
      end
    end
  end

  // ----------------------------------------
  // Access control bank
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      itcm_reg   <= `LCM_RST_ZERO;
      dtcm_reg   <= `LCM_RST_ZERO;
      ahbp_reg   <= `LCM_RST_ZERO;
      slave_port_control_reg <= `LCM_RST_SLAVE_PORT;
    end else begin
      if (wrEn && hitItcm) begin
        itcm_reg <= ppbWdata & `LCM_TCM_RW_MASK;
      end
      if (wrEn && hitDtcm) begin
        dtcm_reg <= ppbWdata & `LCM_TCM_RW_MASK;
      end
      if (wrEn && hitAhbp) begin
        ahbp_reg <= ppbWdata & `LCM_AHBP_RW_MASK;
      end
      if (wrEn && hitAhbscr) begin
        slave_port_control_reg <= ppbWdata;
      end
    end
  end

  // Strap is taken on the first edge after release
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      aux_cache_control_reg      <= `LCM_RST_ZERO;
      strapDone_reg <= 1'b0;
    end else begin
      strapDone_reg <= 1'b1;
      if (!strapDone_reg) begin
        aux_cache_control_reg <= eccConfigured ? `LCM_RST_ZERO : `LCM_RST_AUX_CACHE_CONTROL_NO_ECC;
      end else if (wrEn && hitCacr) begin
        aux_cache_control_reg <= ppbWdata & `LCM_AUX_CACHE_CONTROL_RW_MASK;
      end
    end
  end

  // ----------------------------------------
  // Fault status and reporting
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      aux_bus_fault_status_reg <= `LCM_RST_ZERO;
    end else if (wrEn && hitAbfsr) begin
      // Hardware set wins over a same-cycle write
      aux_bus_fault_status_reg <= ppbWdata | (32'(maintFault) << `LCM_AUX_BUS_FAULT_STATUS_MAINT_BIT);
    end else if (maintFault) begin
      aux_bus_fault_status_reg[`LCM_AUX_BUS_FAULT_STATUS_MAINT_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      privFault_reg <= 1'b0;
      bus_fault_exception_reg  <= 1'b0;
      hard_fault_exception_reg <= 1'b0;
    end else begin
      privFault_reg <= unprivAcc;
      bus_fault_exception_reg  <= maintFault & busFaultHandlerEn;
      hard_fault_exception_reg <= maintFault & ~busFaultHandlerEn;
    end
  end

  // ----------------------------------------
  // Command pulse and read data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cmdValid_reg <= 1'b0;
      cmdKind_reg  <= lcm_pkg::LCM_OP_NONE;
      cmdAddr_reg  <= `LCM_RST_ZERO;
      rdata_reg    <= `LCM_RST_ZERO;
    end else begin
      cmdValid_reg <= opIssue;
      cmdKind_reg  <= opIssue ? opKind : lcm_pkg::LCM_OP_NONE;
      cmdAddr_reg  <= opIssue ? opAddr : `LCM_RST_ZERO;
      rdata_reg    <= rdataNext;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ppbRdata         = rdata_reg;
  assign ppbFault         = privFault_reg;
  assign cmdValid         = cmdValid_reg;
  assign cmdKind          = cmdKind_reg;
  assign cmdAddr          = cmdAddr_reg;
  assign dcacheEnable     = dcEn_reg;
  assign icacheEnable     = icEn_reg;
  // Disabled region goes to the AXI master
  assign itcmEnable       = itcm_reg[`LCM_TCM_EN_BIT];
  assign dtcmEnable       = dtcm_reg[`LCM_TCM_EN_BIT];
  assign periphPortEnable = ahbp_reg[`LCM_AHBP_EN_BIT];
  assign barrierDone      = barDone_reg;
  assign loadStoreHold    = hold_reg;
  assign bus_fault_exception         = bus_fault_exception_reg;
  assign hard_fault_exception        = hard_fault_exception_reg;

endmodule

// ===== design/lcm_defines.svh
`ifndef LCM_DEFINES_SVH
`define LCM_DEFINES_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define LCM_ADDR_CONFIG_CONTROL      32'hE000_ED14
`define LCM_ADDR_CACHE_SIZE_ID       32'hE000_ED80
`define LCM_ADDR_CACHE_SIZE_SELECT   32'hE000_ED84
`define LCM_ADDR_IC_INV_ALL          32'hE000_EF50
`define LCM_ADDR_IC_INV_ADDR         32'hE000_EF58
`define LCM_ADDR_DC_INV_SETWAY       32'hE000_EF60
`define LCM_ADDR_DC_CLEAN_UNIFY      32'hE000_EF64
`define LCM_ADDR_DC_CLEAN_COHERENT   32'hE000_EF68
`define LCM_ADDR_INST_TCM_CONTROL    32'hE000_EF90
`define LCM_ADDR_DATA_TCM_CONTROL    32'hE000_EF94
`define LCM_ADDR_PERIPH_PORT_CONTROL 32'hE000_EF98
`define LCM_ADDR_AUX_CACHE_CONTROL   32'hE000_EF9C
`define LCM_ADDR_SLAVE_PORT_CONTROL  32'hE000_EFA0
`define LCM_ADDR_AUX_BUS_FAULT_STAT  32'hE000_EFA8

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define LCM_DATA_CACHE_ENABLE_BIT_BIT       16
`define LCM_INST_CACHE_ENABLE_BIT_BIT       17
`define LCM_CSSEL_IND_BIT    0
`define LCM_SETWAY_MASK      32'hC000_3FE0
`define LCM_TCM_RW_MASK      32'h0000_0007
`define LCM_TCM_EN_BIT       0
`define LCM_AHBP_RW_MASK     32'h0000_0001
`define LCM_AHBP_EN_BIT      0
`define LCM_AUX_CACHE_CONTROL_RW_MASK     32'h0000_0007
`define LCM_AUX_BUS_FAULT_STATUS_MAINT_BIT  0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCM_RST_ZERO         32'h0000_0000
`define LCM_RST_SLAVE_PORT   32'h0000_0800
`define LCM_RST_AUX_CACHE_CONTROL_NO_ECC  32'h0000_0002

// ----------------------------------------
// Cache geometry (size identification)
// ----------------------------------------
`define LCM_DC_LINE_CODE     3'h1
`define LCM_DC_ASSOC_M1      10'h003
`define LCM_DC_SETS_M1       15'h00FF
`define LCM_IC_LINE_CODE     3'h1
`define LCM_IC_ASSOC_M1      10'h001
`define LCM_IC_SETS_M1       15'h00FF
`define LCM_CACHE_SIZE_ID_PAD       4'h0

// ----------------------------------------
// Maintenance pipeline
// ----------------------------------------
`define LCM_OP_LATENCY       4

`endif

// ===== design/lcm_op_pipe.sv
`include "lcm_defines.svh"

module lcm_op_pipe (
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic issue,
  output logic      done,
  output logic      empty
);

  logic [`LCM_OP_LATENCY-1:0] stage_reg;

  // ----------------------------------------
  // Fixed-latency in-order op tracking
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `LCM_OP_LATENCY; g = g + 1) begin : gStage
      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          stage_reg[g] <= 1'b0;
        end else if (g == 0) begin
          stage_reg[g] <= issue;
        end else begin
          stage_reg[g] <= stage_reg[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  assign done  = stage_reg[`LCM_OP_LATENCY-1];
  assign empty = ~|stage_reg;

endmodule

// ===== design/lcm_pkg.sv
package lcm_pkg;

  typedef enum logic [1:0] {
    LCM_BAR_IDLE = 2'h0,
    LCM_BAR_WAIT = 2'h1,
    LCM_BAR_DONE = 2'h3
  } lcm_barrier_type;

  typedef enum logic [2:0] {
    LCM_OP_NONE           = 3'h0,
    LCM_OP_IC_INV_ALL     = 3'h1,
    LCM_OP_IC_INV_ADDR    = 3'h2,
    LCM_OP_DC_INV_SETWAY  = 3'h3,
    LCM_OP_DC_CLEAN_UNIFY = 3'h4,
    LCM_OP_DC_CLEAN_COHER = 3'h5
  } lcm_op_type;

endpackage

// ===== sim/l1_cache_maint_ctrl_tb.sv
module l1_cache_maint_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, rstn = 1'b0, ppbSel = 1'b0, ppbWrite = 1'b0, ppbPriv = 1'b0;
  logic [31:0] ppbAddr = 32'h0, ppbWdata = 32'h0, ppbRdata, cmdAddr;
  logic        eccConfigured = 1'b0, busFaultHandlerEn = 1'b1, barrierReq = 1'b0, errOn = 1'b0;
  logic        ppbFault, maintErr, cmdValid, dcacheEnable, icacheEnable, itcmEnable, dtcmEnable;
  logic        periphPortEnable, barrierDone, loadStoreHold, bus_fault_exception, hard_fault_exception;
  logic [2:0]  cmdKind;
  int          failCount = 0, numChecks = 0, cycles = 0;

  always #4 clk = ~clk;

  l1_cache_maint_ctrl i_dut (.clk, .rstn, .ppbSel, .ppbWrite, .ppbPriv, .ppbAddr, .ppbWdata, .ppbRdata,
    .ppbFault, .eccConfigured, .busFaultHandlerEn, .maintErr, .barrierReq, .cmdValid, .cmdKind, .cmdAddr,
    .dcacheEnable, .icacheEnable, .itcmEnable, .dtcmEnable, .periphPortEnable, .barrierDone,
    .loadStoreHold, .bus_fault_exception, .hard_fault_exception);
  lcm_cache_resp_model i_resp (.clk, .cmdValid, .errOn, .maintErr);

  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic access(input logic wr, input logic priv, input logic [31:0] addr, input logic [31:0] data);
    @(posedge clk);
    ppbSel   <= 1'b1;
    ppbWrite <= wr;
    ppbPriv  <= priv;
    ppbAddr  <= addr;
    ppbWdata <= data;
    @(posedge clk);
    ppbSel   <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
    access(1'b0, 1'b1, addr, 32'h0);
    check({ppbFault, ppbRdata}, {1'b0, exp});
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    access(1'b1, 1'b1, addr, data);
  endtask

  task automatic op(input logic [31:0] addr, input logic [31:0] data, input logic [2:0] kind,
                    input logic [31:0] expAddr);
    wr(addr, data);
    check({cmdValid, cmdKind, cmdAddr}, {1'b1, kind, expAddr});
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic barrier(input int lo, input int hi);
    int   n;
    logic held;
    n    = 0;
    held = 1'b0;
    @(posedge clk);
    barrierReq <= 1'b1;
    @(posedge clk);
    barrierReq <= 1'b0;
    #1;
    while (barrierDone !== 1'b1 && n < 20) begin
      held = held | loadStoreHold;
      settle();
      n++;
    end
    check({held, barrierDone, n >= lo && n <= hi}, 3'h7);
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failCount++;
      wrapUp();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(32'hE000_EF90, 32'h0);
    rd(32'hE000_EF94, 32'h0);
    rd(32'hE000_EF98, 32'h0);
    rd(32'hE000_EFA0, 32'h0000_0800);
    rd(32'hE000_EF9C, 32'h0000_0002);
    rd(32'hE000_EFA8, 32'h0);
    rd(32'hE000_EF54, 32'h0);
    $display("test reset values done");
    wr(32'hE000_ED84, 32'h0);
    rd(32'hE000_ED84, 32'h0);
    rd(32'hE000_ED80, {4'h0, 15'h00FF, 10'h003, 3'h1});
    wr(32'hE000_ED84, 32'h1);
    rd(32'hE000_ED80, {4'h0, 15'h00FF, 10'h001, 3'h1});
    $display("test geometry done");
    op(32'hE000_EF50, 32'hFFFF_FFFF, 3'h1, 32'h0);
    rd(32'hE000_EF50, 32'h0);
    op(32'hE000_EF60, 32'hFFFF_FFFF, 3'h3, 32'hC000_3FE0);
    for (int s = 0; s < 256; s++) begin
      for (int w = 0; w < 4; w++) begin
        op(32'hE000_EF60, (w << 30) | (s << 5) | 32'h1, 3'h3, (w << 30) | (s << 5));
      end
    end
    barrier(3, 3);
    rd(32'hE000_EF60, 32'h0);
    wr(32'hE000_ED14, 32'hFFFF_FFFF);
    settle();
    check({icacheEnable, dcacheEnable}, 2'h3);
    rd(32'hE000_ED14, 32'h0003_0000);
    barrier(1, 1);
    op(32'hE000_EF64, 32'h2000_1000, 3'h4, 32'h2000_1000);
    op(32'hE000_EF58, 32'h2000_1000, 3'h2, 32'h2000_1000);
    op(32'hE000_EF68, 32'h2000_2000, 3'h5, 32'h2000_2000);
    barrier(3, 3);
    wr(32'hE000_ED14, 32'h0);
    settle();
    check({icacheEnable, dcacheEnable}, 2'h0);
    op(32'hE000_EF50, 32'h0, 3'h1, 32'h0);
    barrier(3, 3);
    wr(32'hE000_ED14, 32'h0002_0000);
    settle();
    check({icacheEnable, dcacheEnable}, 2'h2);
    barrier(1, 1);
    $display("test maintenance done");
    wr(32'hE000_EF90, 32'h1);
    wr(32'hE000_EF94, 32'h1);
    wr(32'hE000_EF98, 32'h1);
    settle();
    check({itcmEnable, dtcmEnable, periphPortEnable}, 3'h7);
    wr(32'hE000_EF90, 32'h0);
    settle();
    check({itcmEnable, dtcmEnable}, 2'h1);
    $display("test routing done");
    access(1'b1, 1'b0, 32'hE000_EF50, 32'h0);
    check({ppbFault, cmdValid}, 2'h2);
    access(1'b1, 1'b0, 32'hE000_EF90, 32'h1);
    check(ppbFault, 1'b1);
    rd(32'hE000_EF90, 32'h0);
    access(1'b0, 1'b0, 32'hE000_ED80, 32'h0);
    check({ppbFault, ppbRdata}, {1'b1, 32'h0});
    $display("test privilege done");
    errOn <= 1'b1;
    op(32'hE000_EF60, 32'h0, 3'h3, 32'h0);
    repeat (4) @(posedge clk);
    #1;
    check({bus_fault_exception, hard_fault_exception}, 2'h2);
    rd(32'hE000_EFA8, 32'h1);
    wr(32'hE000_EFA8, 32'h0);
    @(posedge clk);
    busFaultHandlerEn <= 1'b0;
    op(32'hE000_EF50, 32'h0, 3'h1, 32'h0);
    repeat (4) @(posedge clk);
    #1;
    check({bus_fault_exception, hard_fault_exception}, 2'h1);
    errOn <= 1'b0;
    barrier(1, 1);
    $display("test faults done");
    @(posedge clk);
    eccConfigured <= 1'b1;
    rstn          <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(32'hE000_EF9C, 32'h0);
    rd(32'hE000_EFA8, 32'h0);
    rd(32'hE000_ED14, 32'h0);
    $display("test ecc reset done");
    wrapUp();
  end
endmodule

// ===== sim/lcm_cache_resp_model.sv
module lcm_cache_resp_model (
  input  wire logic clk,
  input  wire logic cmdValid,
  input  wire logic errOn,
  output logic      maintErr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] opPipe = 3'h0;

  // ----------------------------------------
  // Cache side: error shows at op completion
  // ----------------------------------------
  always_ff @(posedge clk) begin
    opPipe <= {opPipe[1:0], cmdValid};
  end

  assign maintErr = errOn && opPipe[2];
endmodule

// ===== sim/lcm_maint_sva.sv
`include "lcm_defines.svh"

module lcm_maint_sva (
  input logic        clk,
  input logic        rstn,
  input logic        ppbSel,
  input logic        ppbWrite,
  input logic        ppbPriv,
  input logic [31:0] ppbAddr,
  input logic [31:0] ppbWdata,
  input logic [31:0] ppbRdata,
  input logic        ppbFault,
  input logic        busFaultHandlerEn,
  input logic        maintErr,
  input logic        barrierReq,
  input logic        cmdValid,
  input logic [2:0]  cmdKind,
  input logic [31:0] cmdAddr,
  input logic        dcacheEnable,
  input logic        icacheEnable,
  input logic        barrierDone,
  input logic        loadStoreHold,
  input logic        bus_fault_exception,
  input logic        hard_fault_exception
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic privWr;
  logic wdDc;
  logic wdIc;

  assign privWr = ppbSel && ppbWrite && ppbPriv;
  assign wdDc   = ppbWdata[`LCM_DATA_CACHE_ENABLE_BIT_BIT];
  assign wdIc   = ppbWdata[`LCM_INST_CACHE_ENABLE_BIT_BIT];

  sequence cfgWrite;
    privWr && ppbAddr == `LCM_ADDR_CONFIG_CONTROL ##1 !ppbSel;
  endsequence

  sequence opFail;
    cmdValid ##3 maintErr;
  endsequence

  unpriv_fault_a: assert property (ppbSel && !ppbPriv |=> ppbFault && !cmdValid && ppbRdata == 32'h0)
    else $error("unprivileged access not refused");
  priv_no_fault_a: assert property (ppbSel && ppbPriv |=> !ppbFault)
    else $error("privileged access faulted");
  maint_read_zero_a: assert property (ppbSel && !ppbWrite && ppbAddr inside {`LCM_ADDR_IC_INV_ALL, `LCM_ADDR_DC_INV_SETWAY}
    |=> ppbRdata == 32'h0) else $error("maintenance register read not zero");
  icinv_cmd_a: assert property (privWr && ppbAddr == `LCM_ADDR_IC_INV_ALL
    |=> cmdValid && cmdKind == 3'h1 && cmdAddr == 32'h0) else $error("invalidate all command wrong");
  setway_cmd_a: assert property (privWr && ppbAddr == `LCM_ADDR_DC_INV_SETWAY
    |=> cmdValid && cmdKind == 3'h3 && cmdAddr == ($past(ppbWdata) & 32'hC000_3FE0)) else $error("set way command wrong");
  cfg_enable_a: assert property (cfgWrite |=> dcacheEnable == $past(wdDc, 2) && icacheEnable == $past(wdIc, 2))
    else $error("cache enables do not follow control write");
  fault_route_a: assert property (opFail |=> bus_fault_exception == busFaultHandlerEn && hard_fault_exception == !busFaultHandlerEn)
    else $error("maintenance fault routed wrongly");
  fault_cause_a: assert property (bus_fault_exception || hard_fault_exception |-> $past(maintErr))
    else $error("fault without failed operation");
  barrier_bound_a: assert property (barrierReq && !loadStoreHold && !barrierDone |-> ##[1:8] barrierDone)
    else $error("barrier never completed");
  hold_end_a: assert property ($fell(loadStoreHold) |-> barrierDone)
    else $error("hold dropped without barrier completion");
  done_after_ops_a: assert property (barrierDone |-> !$past(cmdValid) && !$past(cmdValid, 2) && !$past(cmdValid, 3))
    else $error("barrier completed with operation in flight");
endmodule

bind l1_cache_maint_ctrl lcm_maint_sva u_sva (.clk, .rstn, .ppbSel, .ppbWrite, .ppbPriv, .ppbAddr, .ppbWdata,
  .ppbRdata, .ppbFault, .busFaultHandlerEn, .maintErr, .barrierReq, .cmdValid, .cmdKind, .cmdAddr,
  .dcacheEnable, .icacheEnable, .barrierDone, .loadStoreHold, .bus_fault_exception, .hard_fault_exception);
